// File: include/snf_pkg.sv
// Purpose: Constants for the serial flash command front end
// Assumes: One-byte opcodes, 16-bit array address
// Notes:   Status layout is shared with the array-side logic
package snf_pkg;
    // ********************
    // Sequencer states
    // ********************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPC  = 3'b001,
        ST_ADR  = 3'b010,
        ST_DMY  = 3'b011,
        ST_DIN  = 3'b100,
        ST_END  = 3'b101,
        ST_OUT  = 3'b110,
        ST_IGN  = 3'b111
    } snf_state_e;
    // ********************
    // Opcodes
    // ********************
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_FREAD = 8'h0B;
    localparam logic [7:0] OP_DOUT  = 8'h3B;
    localparam logic [7:0] OP_DIO   = 8'hBB;
    localparam logic [7:0] OP_SE    = 8'h20;
    localparam logic [7:0] OP_BE32  = 8'h52;
    localparam logic [7:0] OP_BE64  = 8'hD8;
    localparam logic [7:0] OP_CE_A  = 8'h60;
    localparam logic [7:0] OP_CE_B  = 8'hC7;
    localparam logic [7:0] OP_PP    = 8'h02;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ_CMD  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE_CMD  = 8'h01;
    localparam logic [7:0] OP_PD    = 8'hB9;
    localparam logic [7:0] OP_WAKE  = 8'hAB;
    localparam logic [7:0] OP_IDRD  = 8'h9F;
    localparam logic [7:0] OP_MDID  = 8'h90;
    localparam logic [7:0] OP_ARM   = 8'h66;
    localparam logic [7:0] OP_RST   = 8'h99;
    // ********************
    // Status bits and counts
    // ********************
    localparam int         SB_WIP    = 0;
    localparam int         SB_WEL    = 1;
    localparam int         SB_BP0    = 2;
    localparam int         SB_BP1    = 3;
    localparam int         SB_STATUS_WRITE_DISABLE   = 7;
    localparam logic [7:0] SR_WMASK  = 8'hBC;
    localparam logic [7:0] SR_RST    = 8'h00;
    localparam logic [2:0] NB_ONE    = 3'h1;
    localparam logic [2:0] NB_ADR    = 3'h3;
    localparam logic [2:0] NB_PPMIN  = 3'h5;
    localparam logic [3:0] DMY_1L    = 4'h8;
    localparam logic [3:0] DMY_2L    = 4'h4;
    localparam logic [2:0] BITS_1L   = 3'h7;
    localparam logic [2:0] BITS_2L   = 3'h3;
    localparam int         PAGE      = 256;
    // Input sampling vector positions
    localparam int IN_CS = 0;
    localparam int IN_SCK = 1;
    localparam int IN_D0 = 2;
    localparam int IN_D1 = 3;
    localparam int IN_WP = 4;
    localparam int NIN = 5;
endpackage

// File: rtl/snf_cmd.sv
// Purpose: Serial command front end of a 64 KB NOR flash
// Assumes: Serial clock far slower than i_ref_clk
// Notes:   Array timing lives outside; i_op_done ends busy
`timescale 1ns/1ps
// Operation
// - Works with clock idling low or high
// - Sample on rising edge, drive on falling
// - Unknown opcode: ignore until select rises
// - Valid opcode: active until select rises
// - Write commands need byte-exact select rise
// - Read commands may end after any bit
// - Array reads ignored while busy
// - Changes need write enable latch set
// - Power-down accepts only wake or signature
// - Reset puts sequencer in standby
// - Low protect bits nonzero protect all
// - Low protect pin freezes protect bits
// - 64 KB, sixteen 4 KB sectors
// - Sector, 32K, 64K or chip erase
// - One 256-byte page per program
// - Busy bit shows program, erase or status write
// - Single fast read: eight dummy clocks
// - Dual I/O fast read: four dummy clocks
// - Dual mode drives two bits per clock
// - Deselected and idle means standby
// - Read opcodes take three address bytes
// - Erase and program opcode decode
// - Latch set by 06h, cleared by 04h
module snf_cmd
    import snf_pkg::*;
#(
    parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] TYP_ID = 8'h11, // Arbitrary value
    parameter logic [7:0] DEN_ID = 8'h22, // Arbitrary value
    parameter logic [7:0] ELE_ID = 8'h33  // Arbitrary value
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic        i_sio0,
    input  wire logic        i_sio1,
    input  wire logic        i_wp_n,
    input  wire logic        i_op_done,
    input  wire logic [7:0]  i_mem_rdata,
    input  wire logic [7:0]  i_prog_idx,
    output logic             o_sio0,
    output logic             o_sio0_oe,
    output logic             o_sio1,
    output logic             o_sio1_oe,
    output logic [15:0]      o_mem_addr,
    output logic             o_erase_start,
    output logic [1:0]       o_erase_kind,
    output logic             o_prog_start,
    output logic [15:0]      o_op_addr,
    output logic [7:0]       o_prog_byte,
    output logic [7:0]       o_status,
    output logic             o_deep_pd
);
    // ********************
    // Pin sampling
    // ********************
    logic [NIN-1:0] s1_q, s2_q, s3_q; // Three-stage chain
    logic [NIN-1:0] flt_q;            // Agreed level
    logic           sck_p_q, cs_p_q;  // Previous levels
    // Change accepted once stages two and three agree
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            flt_q <= '1;
        end else begin
            s1_q <= {i_wp_n, i_sio1, i_sio0, i_sclk, i_cs_n};
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= (flt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
        end
    end
    // Edge history of the agreed levels
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_p_q <= 1'b0;
            cs_p_q <= 1'b1;
        end else begin
            sck_p_q <= flt_q[IN_SCK];
            cs_p_q <= flt_q[IN_CS];
        end
    end
    // Edges found from levels, so idle polarity is free
    wire cs_hi   = flt_q[IN_CS];
    wire cs_fall = cs_p_q & ~cs_hi;
    wire cs_rise = ~cs_p_q & cs_hi;
    wire rise    = flt_q[IN_SCK] & ~sck_p_q & ~cs_hi;
    wire fall    = ~flt_q[IN_SCK] & sck_p_q & ~cs_hi;
    wire d0      = flt_q[IN_D0];
    wire d1      = flt_q[IN_D1];
    wire wp_hi   = flt_q[IN_WP];
    // ********************
    // Core state
    // ********************
    snf_state_e     st_q, st_d;   // Sequencer
    logic [7:0]     cmd_q;        // Current opcode
    logic [7:0]     in_sr_q;      // Input shifter
    logic [2:0]     bit_q;        // Bit in byte
    logic [2:0]     nbyte_q;      // Bytes seen, saturating
    logic [15:0]    adr_q;        // Address, low 16 bits
    logic [3:0]     dmy_q;        // Dummy clocks left
    logic [3:0]     dseen_q;      // Dummy clocks seen
    logic [7:0]     sr_q;         // Status register
    logic           dp_q;         // Deep power-down
    logic           arm_q;        // Soft reset armed
    logic [7:0]     out_sr_q;     // Output shifter
    logic [2:0]     ocnt_q;       // Output slots left
    logic [1:0]     idx_q;        // Id byte index
    logic [7:0]     pidx_q;       // Page write index
    logic [7:0]     pb_q [PAGE];  // Page buffer
    // Opcode classes
    function automatic logic f_rd(input logic [7:0] o);
        f_rd = o == OP_READ || o == OP_FREAD || o == OP_DOUT
               || o == OP_DIO;
    endfunction
    function automatic logic f_er(input logic [7:0] o);
        f_er = o == OP_SE || o == OP_BE32 || o == OP_BE64
               || o == OP_CE_A || o == OP_CE_B;
    endfunction
    // ********************
    // Input decode
    // ********************
    wire dual_in = st_q == ST_ADR && cmd_q == OP_DIO;
    wire bdone   = dual_in ? bit_q == 3'h6 : bit_q == BITS_1L;
    wire [7:0] in_nx = dual_in ? {in_sr_q[5:0], d1, d0}
                               : {in_sr_q[6:0], d0};
    wire [2:0] bit_inc = dual_in ? 3'h2 : 3'h1;
    wire [7:0] opc = in_nx;
    // Chip erase carries no address, so it ends after the opcode
    wire opc_ce  = opc == OP_CE_A || opc == OP_CE_B;
    wire opc_adr = f_rd(opc) || (f_er(opc) && !opc_ce)
                   || opc == OP_PP || opc == OP_WAKE || opc == OP_MDID;
    wire opc_known = opc_adr || opc_ce || opc == OP_WRITE_ENABLE_CMD || opc == OP_WRITE_DISABLE_CMD
                     || opc == OP_STATUS_READ_CMD || opc == OP_STATUS_WRITE_CMD
                     || opc == OP_PD || opc == OP_IDRD
                     || opc == OP_ARM || opc == OP_RST;
    // Busy blocks array reads and the 9Fh id read; power-down admits one
    wire opc_ign = dp_q ? opc != OP_WAKE
                 : !opc_known || (sr_q[SB_WIP]
                   && (f_rd(opc) || opc == OP_IDRD));
    wire opc_out = opc == OP_STATUS_READ_CMD || opc == OP_IDRD;
    snf_state_e opc_nx, adr_nx;
    assign opc_nx = opc_ign ? ST_IGN
                  : opc_adr ? ST_ADR
                  : opc_out ? ST_OUT
                  : opc == OP_STATUS_WRITE_CMD ? ST_DIN : ST_END;
    assign adr_nx = (cmd_q == OP_FREAD || cmd_q == OP_DOUT
                     || cmd_q == OP_DIO) ? ST_DMY
                  : cmd_q == OP_PP ? ST_DIN
                  : f_er(cmd_q) ? ST_END : ST_OUT;
    wire adr_done = st_q == ST_ADR && bdone && nbyte_q == NB_ADR;
    // Next sequencer state
    always_comb begin
        st_d = st_q;
        if (cs_fall) begin
            st_d = ST_OPC;
        end else if (cs_hi) begin
            st_d = ST_IDLE;
        end else if (rise) begin
            case (st_q)
                ST_OPC: begin
                    if (bdone) st_d = opc_nx;
                end
                ST_ADR: begin
                    if (adr_done) st_d = adr_nx;
                end
                ST_DMY: begin
                    if (dmy_q == 4'h1) st_d = ST_OUT;
                end
                ST_DIN: begin
                    if (bdone && cmd_q == OP_STATUS_WRITE_CMD) st_d = ST_END;
                end
                // Any clock past the body spoils the command
                ST_END: st_d = ST_IGN;
                default: st_d = st_q;
            endcase
        end
    end
    // Sequencer register; reset lands in standby
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) st_q <= ST_IDLE;
        else st_q <= st_d;
    end
    // Bit, byte and address capture on rising edges
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_q <= 3'h0;
            nbyte_q <= 3'h0;
            in_sr_q <= 8'h00;
            cmd_q <= 8'h00;
            adr_q <= 16'h0000;
        end else if (cs_fall) begin
            bit_q <= 3'h0;
            nbyte_q <= 3'h0;
        end else if (rise) begin
            bit_q <= bit_q + bit_inc;
            in_sr_q <= in_nx;
            if (bdone && nbyte_q != 3'h7) nbyte_q <= nbyte_q + 3'h1;
            if (st_q == ST_OPC && bdone) cmd_q <= opc;
            // Top address byte falls off the end
            if (st_q == ST_ADR && bdone) adr_q <= {adr_q[7:0], in_nx};
        end
    end
    // Dummy clock counting
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            dmy_q <= 4'h0;
            dseen_q <= 4'h0;
        end else if (adr_done && rise) begin
            dmy_q <= cmd_q == OP_DIO ? DMY_2L : DMY_1L;
            dseen_q <= 4'h0;
        end else if (rise && st_q == ST_DMY) begin
            dmy_q <= dmy_q - 4'h1;
            dseen_q <= dseen_q + 4'h1;
        end
    end
    // ********************
    // Command execution
    // ********************
    wire bnd      = bit_q == 3'h0;
    wire exec_end = cs_rise && st_q == ST_END && bnd;
    wire exec_pp  = cs_rise && st_q == ST_DIN && bnd
                    && cmd_q == OP_PP && nbyte_q >= NB_PPMIN;
    wire exec_wk  = cs_rise && st_q == ST_ADR && bnd
                    && cmd_q == OP_WAKE && nbyte_q == NB_ONE;
    wire we_ok    = sr_q[SB_WEL] & ~sr_q[SB_WIP];
    wire prot     = |sr_q[SB_BP1:SB_BP0];
    wire go_er    = exec_end && f_er(cmd_q) && we_ok && !prot;
    wire go_pp    = exec_pp && we_ok && !prot;
    wire go_status_write_cmd  = exec_end && cmd_q == OP_STATUS_WRITE_CMD && we_ok;
    wire wr_set   = go_er || go_pp || go_status_write_cmd;
    wire soft_rst = exec_end && cmd_q == OP_RST && arm_q;
    wire wel_clr  = wr_set || soft_rst
                    || (exec_end && cmd_q == OP_WRITE_DISABLE_CMD);
    wire wel_set  = exec_end && cmd_q == OP_WRITE_ENABLE_CMD;
    // Pin low keeps protect and lock bits as they are
    wire [7:0] sr_wr = wp_hi ? (sr_q & ~SR_WMASK) | (in_sr_q & SR_WMASK)
                             : sr_q;
    wire [7:0] sr_base = go_status_write_cmd ? sr_wr : sr_q;
    // Status: busy set wins over the done pulse
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sr_q <= SR_RST;
        end else begin
            sr_q <= sr_base;
            sr_q[SB_WIP] <= wr_set | (sr_q[SB_WIP] & ~i_op_done);
            sr_q[SB_WEL] <= wel_set | (sr_q[SB_WEL] & ~wel_clr);
        end
    end
    // Power-down and soft reset arming
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            dp_q <= 1'b0;
            arm_q <= 1'b0;
        end else begin
            if (exec_end && cmd_q == OP_PD && !sr_q[SB_WIP]) dp_q <= 1'b1;
            else if (exec_wk) dp_q <= 1'b0;
            // Any other opcode between arm and reset disarms
            if (exec_end && cmd_q == OP_ARM) arm_q <= 1'b1;
            else if (soft_rst || (rise && st_q == ST_OPC && bdone
                     && opc != OP_RST)) arm_q <= 1'b0;
        end
    end
    // Array-side start pulses and operation address
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_erase_start <= 1'b0;
            o_prog_start <= 1'b0;
            o_erase_kind <= 2'h0;
            o_op_addr <= 16'h0000;
        end else begin
            o_erase_start <= go_er;
            o_prog_start <= go_pp;
            if (wr_set) o_op_addr <= adr_q;
            if (go_er) o_erase_kind <= cmd_q == OP_SE ? 2'h0
                : cmd_q == OP_BE32 ? 2'h1
                : cmd_q == OP_BE64 ? 2'h2 : 2'h3;
        end
    end
    // ********************
    // Page buffer
    // ********************
    wire pb_clr = rise && st_q == ST_OPC && bdone && opc == OP_PP;
    wire pb_we  = rise && st_q == ST_DIN && bdone && cmd_q == OP_PP;
    // Entries start erased; bytes wrap inside the page
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) pidx_q <= 8'h00;
        else if (adr_done && rise) pidx_q <= in_nx;
        else if (pb_we) pidx_q <= pidx_q + 8'h01;
    end
    for (genvar g = 0; g < PAGE; g++) begin : g_pb
        always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) pb_q[g] <= 8'hFF;
            else if (pb_clr) pb_q[g] <= 8'hFF;
            else if (pb_we && pidx_q == 8'(g)) pb_q[g] <= in_nx;
        end
    end
    // Registered read port for the array
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) o_prog_byte <= 8'hFF;
        else o_prog_byte <= pb_q[i_prog_idx];
    end
    // ********************
    // Output path
    // ********************
    wire dual_out = cmd_q == OP_DOUT || cmd_q == OP_DIO;
    wire [7:0] id_b = idx_q == 2'h0 ? MFR_ID
                    : idx_q == 2'h1 ? TYP_ID : DEN_ID;
    wire [7:0] nb = cmd_q == OP_STATUS_READ_CMD ? sr_q
                  : cmd_q == OP_IDRD ? id_b
                  : cmd_q == OP_WAKE ? ELE_ID
                  : cmd_q == OP_MDID
                    ? ((idx_q[0] ^ adr_q[0]) ? ELE_ID : MFR_ID)
                  : i_mem_rdata;
    wire       load = ocnt_q == 3'h0;
    wire [7:0] cur  = load ? nb : out_sr_q;
    wire [1:0] idx_nx = (cmd_q == OP_IDRD && idx_q == 2'h2)
                        ? 2'h0 : idx_q + 2'h1;
    // Shift on falling edges; deselect floats at once
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sio0 <= 1'b0;
            o_sio1 <= 1'b0;
            o_sio0_oe <= 1'b0;
            o_sio1_oe <= 1'b0;
            out_sr_q <= 8'h00;
            ocnt_q <= 3'h0;
            idx_q <= 2'h0;
        end else if (cs_hi || st_q != ST_OUT) begin
            o_sio0_oe <= 1'b0;
            o_sio1_oe <= 1'b0;
            ocnt_q <= 3'h0;
            idx_q <= 2'h0;
        end else if (fall) begin
            o_sio1 <= cur[7];
            o_sio1_oe <= 1'b1;
            if (dual_out) begin
                o_sio0 <= cur[6];
                o_sio0_oe <= 1'b1;
                out_sr_q <= {cur[5:0], 2'b00};
                ocnt_q <= load ? BITS_2L : ocnt_q - 3'h1;
            end else begin
                out_sr_q <= {cur[6:0], 1'b0};
                ocnt_q <= load ? BITS_1L : ocnt_q - 3'h1;
            end
            if (load) idx_q <= idx_nx;
        end
    end
    // Read address: loaded at address end, steps per byte
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) o_mem_addr <= 16'h0000;
        else if (adr_done && rise) o_mem_addr <= {adr_q[7:0], in_nx};
        else if (fall && st_q == ST_OUT && load && f_rd(cmd_q))
            o_mem_addr <= o_mem_addr + 16'h0001;
    end
    assign o_status  = sr_q;
    assign o_deep_pd = dp_q;
    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    property p_desel_quiet;
        cs_hi |=> !o_sio1_oe && !o_sio0_oe;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet)
        else $error("output driven while deselected");
    property p_idle_standby;
        cs_hi && !cs_fall |=> st_q == ST_IDLE;
    endproperty
    a_idle_standby: assert property (p_idle_standby)
        else $error("not in standby while deselected");
    property p_bad_opc;
        rise && st_q == ST_OPC && bdone && !dp_q && !opc_known
        |=> st_q == ST_IGN [*2];
    endproperty
    a_bad_opc: assert property (p_bad_opc)
        else $error("unknown opcode not ignored");
    property p_pd_filter;
        rise && st_q == ST_OPC && bdone && dp_q && opc != OP_WAKE
        |=> st_q == ST_IGN;
    endproperty
    a_pd_filter: assert property (p_pd_filter)
        else $error("command taken in power-down");
    property p_busy_read;
        rise && st_q == ST_OPC && bdone && sr_q[SB_WIP] && f_rd(opc)
        |=> st_q == ST_IGN;
    endproperty
    a_busy_read: assert property (p_busy_read)
        else $error("array read while busy");
    property p_wel_needed;
        $rose(sr_q[SB_WIP]) |-> $past(sr_q[SB_WEL]) && !sr_q[SB_WEL];
    endproperty
    a_wel_needed: assert property (p_wel_needed)
        else $error("write without latch");
    property p_protect;
        o_erase_start || o_prog_start |-> $past(sr_q[SB_BP1:SB_BP0], 2)
        == 2'b00 && o_status[SB_WIP];
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected array changed");
    property p_wp_lock;
        !wp_hi && !cs_rise |=> $stable(sr_q & SR_WMASK);
    endproperty
    a_wp_lock: assert property (p_wp_lock)
        else $error("locked bits changed");
    property p_dummy;
        st_q == ST_DMY && st_d == ST_OUT |-> dseen_q ==
        (cmd_q == OP_DIO ? DMY_2L : DMY_1L) - 4'h1;
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("wrong dummy clock count");
    property p_edge_out;
        $changed(o_sio1) |-> $past(fall);
    endproperty
    a_edge_out: assert property (p_edge_out)
        else $error("output changed off falling edge");
    c_prog: cover property (o_prog_start);
    c_erase: cover property (o_erase_start);
    c_dual: cover property (o_sio0_oe && o_sio1_oe);
    c_pd: cover property ($rose(dp_q));
endmodule

// File: tb/snf_host.sv
// Purpose: Host controller model that frames serial flash commands
// Assumes: Mode 0 or 3, half period of 20 reference cycles (80 ns)
// Notes:   Clock stands still at its idle level between frames
`timescale 1ns/1ps
module snf_host (
    input  wire logic i_ref_clk,
    input  wire logic i_sio0,
    input  wire logic i_sio1,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi,
    output logic      o_mosi_oe
);
    logic mode3_q; // Clock idles high when set
    initial begin
        mode3_q = 1'b0;
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_mosi_oe = 1'b1;
    end
    // Half a serial clock, changes land on falling reference edges
    task automatic half();
        repeat (20) @(negedge i_ref_clk);
    endtask
    // Select with the clock parked at the idle level of the mode
    task automatic sel(input logic m3);
        mode3_q = m3;
        o_sclk = m3;
        half();
        o_cs_n = 1'b0;
    endtask
    // Drive in the low phase, sample both lines at the rise
    task automatic bit1(input logic b, output logic [1:0] r);
        o_sclk = 1'b0;
        o_mosi = b;
        half();
        o_sclk = 1'b1;
        r = {i_sio1, i_sio0};
        half();
    endtask
    // One byte, most significant bit first
    task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
        logic [1:0] s;
        for (int i = 7; i >= 0; i--) begin
            bit1(b[i], s);
            r[i] = s[1];
        end
    endtask
    // Dual read: host lets go of line 0, two bits per clock
    task automatic xdual(output logic [7:0] r);
        logic [1:0] s;
        o_mosi_oe = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            bit1(1'b0, s);
            r[2*i+:2] = s;
        end
    endtask
    // Park the clock, release select; data line shows the inverse
    task automatic desel();
        o_sclk = mode3_q;
        half();
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        o_mosi_oe = 1'b1;
        half();
    endtask
endmodule

// File: tb/tb_snf_cmd.sv
// Purpose: Self-checking bench for the serial flash command front end
// Assumes: Array data is a fixed function of the read address
// Notes:   Only the host model moves chip select and serial clock
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_snf_cmd;
    import snf_pkg::*;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wp_n = 1'b1, i_op_done = 1'b0;
    logic tog = 1'b0, cs_n, sclk, mosi, mosi_oe, d0, d1;
    logic sio0, sio0_oe, sio1, sio1_oe, er_st, pr_st, deep_pd;
    logic [7:0] mem_rd = 8'h00, prog_idx = 8'h00, prog_byte, status, rx;
    logic [15:0] mem_addr, op_addr, addr_c;
    logic [1:0] er_kind, kind_c, d0_unused;
    logic [23:0] a;
    logic [7:0] ops [5] = '{OP_SE, OP_BE32, OP_BE64, OP_CE_A, OP_CE_B};
    logic [7:0] rds [3] = '{OP_READ, OP_FREAD, OP_DOUT};
    int errors = 0, n_tests = 0, n_er = 0, n_pr = 0, seed = 9;
    // Undriven lines show a pattern that changes every cycle
    assign d0 = sio0_oe ? sio0 : (mosi_oe ? mosi : tog);
    assign d1 = sio1_oe ? sio1 : tog;
    always #2 i_ref_clk = ~i_ref_clk;
    always @(negedge i_ref_clk) begin
        tog <= ~tog;
        mem_rd <= mem_f(mem_addr);
    end
    // Capture every start pulse in the cycle that it stands
    always @(posedge i_ref_clk) begin
        if (er_st) begin
            n_er++;
            kind_c = er_kind;
            addr_c = op_addr;
        end
        if (pr_st) n_pr++;
    end
    snf_cmd snf_cmd_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_cs_n(cs_n), .i_sclk(sclk), .i_sio0(d0), .i_sio1(d1),
        .i_wp_n(i_wp_n), .i_op_done(i_op_done), .i_mem_rdata(mem_rd),
        .i_prog_idx(prog_idx), .o_sio0(sio0), .o_sio0_oe(sio0_oe),
        .o_sio1(sio1), .o_sio1_oe(sio1_oe), .o_mem_addr(mem_addr),
        .o_erase_start(er_st), .o_erase_kind(er_kind),
        .o_prog_start(pr_st), .o_op_addr(op_addr),
        .o_prog_byte(prog_byte), .o_status(status), .o_deep_pd(deep_pd));
    snf_host snf_host_inst (.i_ref_clk(i_ref_clk), .i_sio0(d0),
        .i_sio1(d1), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
        .o_mosi_oe(mosi_oe));
    function automatic logic [7:0] mem_f(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'hA5;
    endfunction
    function automatic logic [1:0] kind_f(input logic [7:0] op);
        return (op == OP_SE) ? 2'h0 : (op == OP_BE32) ? 2'h1 :
               (op == OP_BE64) ? 2'h2 : 2'h3;
    endfunction
    // Opcode and optional three address bytes, select left low
    task automatic frame(input logic [7:0] op, input bit adr,
                         input logic m3);
        snf_host_inst.sel(m3);
        snf_host_inst.xbyte(op, rx);
        if (adr) for (int i = 2; i >= 0; i--)
            snf_host_inst.xbyte(a[8*i+:8], rx);
    endtask
    task automatic cmd(input logic [7:0] op);
        frame(op, 0, 1'b0);
        snf_host_inst.desel();
    endtask
    task automatic status_read_cmd();
        frame(OP_STATUS_READ_CMD, 0, 1'b1);
        snf_host_inst.xbyte(8'h00, rx);
        snf_host_inst.desel();
    endtask
    task automatic done();
        @(negedge i_ref_clk) i_op_done = 1'b1;
        @(negedge i_ref_clk) i_op_done = 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        errors++;
        summarize();
    end
    initial begin
        repeat (6) @(negedge i_ref_clk);
        i_rst = 1'b0;
        repeat (8) @(negedge i_ref_clk);
        `CHK(status, SR_RST)
        `CHK(sio1_oe, 1'b0)
        cmd(OP_WRITE_ENABLE_CMD);
        status_read_cmd();
        `CHK(rx[SB_WEL], 1'b1)
        cmd(OP_WRITE_DISABLE_CMD);
        `CHK(status[SB_WEL], 1'b0)
        // Nine clocks: select rises off the byte boundary
        frame(OP_WRITE_ENABLE_CMD, 0, 1'b0);
        snf_host_inst.bit1(1'b0, d0_unused);
        snf_host_inst.desel();
        `CHK(status[SB_WEL], 1'b0)
        $display("end: latch and boundary");
        for (int k = 0; k < 5; k++) begin
            a = 24'($random(seed));
            cmd(OP_WRITE_ENABLE_CMD);
            frame(ops[k], k < 3, k[0]);
            snf_host_inst.desel();
            `CHK(n_er, k + 1)
            `CHK(kind_c, kind_f(ops[k]))
            if (k < 3) `CHK(addr_c, a[15:0])
            status_read_cmd();
            `CHK(rx[1:0], 2'b01)
            frame(OP_READ, 1, 1'b0);
            snf_host_inst.xbyte(8'h00, rx);
            `CHK(sio1_oe, 1'b0)
            snf_host_inst.desel();
            done();
            `CHK(status[SB_WIP], 1'b0)
        end
        frame(OP_SE, 1, 1'b0);
        snf_host_inst.desel();
        `CHK(n_er, 5)
        $display("end: erase kinds");
        for (int k = 0; k < 3; k++) begin
            a = 24'($random(seed));
            frame(rds[k], 1, k[0]);
            if (k > 0) snf_host_inst.xbyte(8'h00, rx);
            for (int j = 0; j < 2; j++) begin
                if (k == 2) snf_host_inst.xdual(rx);
                else snf_host_inst.xbyte(8'h00, rx);
                `CHK(rx, mem_f(a[15:0] + 16'(j)))
            end
            snf_host_inst.bit1(1'b0, d0_unused);
            snf_host_inst.desel();
            `CHK({sio0_oe, sio1_oe}, 2'b00)
        end
        frame(8'hFF, 0, 1'b0);
        snf_host_inst.xbyte(8'h00, rx);
        `CHK(sio1_oe, 1'b0)
        snf_host_inst.desel();
        cmd(OP_PD);
        cmd(OP_WRITE_ENABLE_CMD);
        `CHK({deep_pd, status[SB_WEL]}, 2'b10)
        cmd(OP_WAKE);
        `CHK(deep_pd, 1'b0)
        $display("end: reads and power-down");
        a = 24'h0012C4;
        cmd(OP_WRITE_ENABLE_CMD);
        frame(OP_PP, 1, 1'b0);
        snf_host_inst.xbyte(8'h3C, rx);
        snf_host_inst.desel();
        prog_idx = 8'hC4;
        repeat (3) @(negedge i_ref_clk);
        `CHK(n_pr, 1)
        `CHK(prog_byte, 8'h3C)
        done();
        cmd(OP_WRITE_ENABLE_CMD);
        frame(OP_STATUS_WRITE_CMD, 0, 1'b0);
        snf_host_inst.xbyte(8'h04, rx);
        snf_host_inst.desel();
        done();
        cmd(OP_WRITE_ENABLE_CMD);
        frame(OP_SE, 1, 1'b0);
        snf_host_inst.desel();
        `CHK(n_er, 5)
        i_wp_n = 1'b0;
        cmd(OP_WRITE_ENABLE_CMD);
        frame(OP_STATUS_WRITE_CMD, 0, 1'b0);
        snf_host_inst.xbyte(8'h00, rx);
        snf_host_inst.desel();
        done();
        `CHK(status[SB_BP0], 1'b1)
        // Armed soft reset drops the latch
        cmd(OP_WRITE_ENABLE_CMD);
        cmd(OP_ARM);
        cmd(OP_RST);
        `CHK(status[SB_WEL], 1'b0)
        $display("end: program and protection");
        summarize();
    end
endmodule
